//--- design/pbs_addr_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// prefix comparator, purely combinational
module pbs_addr_cmp #(
  parameter int cmp_addr_width = 32,
  parameter int decoded_msb_count = 24,
  parameter logic [31:0] range_base = 32'hFFFF_8000
) (
  // address side
  input wire logic [cmp_addr_width-1:0] addr_i,
  input wire logic addr_valid_i,
  // select out, must be registered by the user
  output logic periph_select_out_o
);
  localparam int LSB = cmp_addr_width - decoded_msb_count;

  // wider count compares more bits, so claims less space
  assign periph_select_out_o = addr_valid_i &&
    (addr_i[cmp_addr_width-1:LSB] == range_base[cmp_addr_width-1:LSB]);
endmodule : pbs_addr_cmp
`default_nettype wire

//--- design/pbs_cfg.svh
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

// wishbone register byte offsets
`define PBS_CTRL_OFS 8'h00
`define PBS_STAT_OFS 8'h04

// control register fields
`define PBS_CTRL_LAT_LSB 0
`define PBS_CTRL_LAT_W 5
`define PBS_CTRL_ERR_BIT 8
`define PBS_CTRL_RTY_BIT 9
`define PBS_CTRL_RST 32'h0000_0000

// status register fields
`define PBS_STAT_XFER_LSB 0
`define PBS_STAT_ABRT_LSB 16
`define PBS_STAT_CNT_W 16

// response window: arbiter times out after this many cycles
`define PBS_RESP_CYC 16
// cycles from select to the first possible acknowledge, latency zero
`define PBS_ACK_BASE 3
// longest latency still answered inside the window
`define PBS_LAT_MAX (`PBS_RESP_CYC - `PBS_ACK_BASE - 1)

// defaults of the decoded range
`define PBS_BASE_DEF 32'hFFFF_8000
`define PBS_TOP_DEF 32'hFFFF_80FF
`define PBS_MSB_DEF 24

`endif

//--- design/pbs_pkg.sv
`default_nettype none
package pbs_pkg;
  // transfer engine states
  typedef enum logic [1:0] {
    PBS_IDLE,
    PBS_WAIT,
    PBS_DONE,
    PBS_RETRY
  } pbs_state_e;

  typedef logic [31:0] pbs_word_t;
endpackage : pbs_pkg
`default_nettype wire

//--- design/pbs_slave.sv
// What this block does
// - long transfers raise timeout suppress within 16 cycles
// - suppress stays high until transfer can finish
// - on abort suppress falls after one cycle
// - error may rise from decode onward
// - error valid whenever acknowledge is high
// - error driven only while selected
// - idle slave drives all outputs zero
// - untargeted decode leaves all outputs zero
// - compare address against base, top bounds range
// - address and data buses are 32 bits
// - select when top N bits match base
// - more decoded bits claim less space
// - comparator valid input is bus select
// - comparator address is the bus address
// - comparator output registered before use
// - comparator address width is 32
// - bidirectional pins split into three ports
// - interrupt outputs optional, application defined
// - acknowledge lasts exactly one cycle per transfer
// - acknowledge or retry within 16 cycles unless suppressed
// - never acknowledge while asserting retry
`timescale 1ns/1ps
`default_nettype none
`include "pbs_cfg.svh"
module pbs_slave #(
  parameter int bus_addr_width = 32,
  parameter int bus_data_width = 32,
  parameter logic [31:0] range_base = `PBS_BASE_DEF,
  parameter logic [31:0] range_top = `PBS_TOP_DEF,
  parameter int decoded_msb_count = `PBS_MSB_DEF,
  parameter int mem_depth = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // peripheral bus, master side
  input wire logic [bus_addr_width-1:0] opb_addr_i,
  input wire logic [3:0] opb_be_i,
  input wire logic [bus_data_width-1:0] opb_wdata_i,
  input wire logic opb_rnw_i,
  input wire logic opb_select_i,
  // peripheral bus, slave responses
  output pbs_pkg::pbs_word_t sl_rdata_o,
  output logic sl_xfer_ack_o,
  output logic sl_err_ack_o,
  output logic sl_retry_o,
  output logic sl_tout_sup_o,
  // wishbone control port
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import pbs_pkg::*;

  // every port is one-way, so no pin needs the three-port split
  // interrupt outputs are optional and this slave has none

  localparam int IDX_W = $clog2(mem_depth);
  localparam int LAT_W = `PBS_CTRL_LAT_W;
  localparam int CNT_W = `PBS_STAT_CNT_W;
  localparam logic [LAT_W-1:0] LAT_MAX = LAT_W'(`PBS_LAT_MAX);

  // lane merge used by both ports; lane 3 is the most significant byte
  function automatic pbs_word_t merge(input pbs_word_t old, input pbs_word_t nw,
                                      input logic [3:0] sel);
    pbs_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  pbs_state_e state;
  logic hit_q;
  logic periph_select_out;
  logic [LAT_W-1:0] wait_cnt;
  pbs_word_t ctrl;
  logic [CNT_W-1:0] xfer_cnt;
  logic [CNT_W-1:0] abort_cnt;
  pbs_word_t mem [mem_depth];
  logic [IDX_W-1:0] idx;
  logic wb_req;
  logic start;
  logic finish;
  logic aborted;
  logic out_range;
  logic [LAT_W-1:0] lat;

  // both buses are fixed at 32 bits
  if (bus_addr_width != 32 || bus_data_width != 32) begin : g_width_chk
    $error("bus widths must be 32");
  end

  // prefix decode on the live bus address and select
  pbs_addr_cmp #(
    .cmp_addr_width(32),
    .decoded_msb_count(decoded_msb_count),
    .range_base(range_base)
  ) u_cmp (
    .addr_i(opb_addr_i),
    .addr_valid_i(opb_select_i),
    .periph_select_out_o(periph_select_out)
  );

  // comparator output is only ever used through this flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= periph_select_out;
    end
  end

  // engine events; stale hit_q is masked by the live select
  assign lat = ctrl[`PBS_CTRL_LAT_LSB +: LAT_W];
  assign start = (state == PBS_IDLE) && hit_q && opb_select_i;
  assign finish = (state == PBS_WAIT) && opb_select_i && (wait_cnt == '0);
  assign aborted = (state == PBS_WAIT) && !opb_select_i;
  assign idx = opb_addr_i[2 +: IDX_W];
  // top bound of the range; beyond it inside the prefix is an error
  assign out_range = opb_addr_i > range_top;

  // transfer engine state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PBS_IDLE;
      wait_cnt <= '0;
    end else begin
      unique case (state)
        PBS_IDLE: begin
          if (start && ctrl[`PBS_CTRL_RTY_BIT]) begin
            state <= PBS_RETRY;
          end else if (start) begin
            state <= PBS_WAIT;
            wait_cnt <= lat;
          end
        end
        PBS_WAIT: begin
          if (aborted) begin
            state <= PBS_IDLE;
          end else if (finish) begin
            state <= PBS_DONE;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        PBS_DONE: begin
          // wait for the master to let go before a new decode
          if (!opb_select_i) begin
            state <= PBS_IDLE;
          end
        end
        PBS_RETRY: begin
          if (!opb_select_i) begin
            state <= PBS_IDLE;
          end
        end
      endcase
    end
  end

  // acknowledge: one cycle, never alongside retry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sl_xfer_ack_o <= 1'b0;
    end else begin
      sl_xfer_ack_o <= finish;
    end
  end

  // error rides with the acknowledge only, so it is valid then
  // and low whenever this slave is not the target
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sl_err_ack_o <= 1'b0;
    end else begin
      sl_err_ack_o <= finish && (ctrl[`PBS_CTRL_ERR_BIT] || out_range);
    end
  end

  // retry holds until the master deselects; exclusive with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sl_retry_o <= 1'b0;
    end else if (start && ctrl[`PBS_CTRL_RTY_BIT]) begin
      sl_retry_o <= 1'b1;
    end else if (!opb_select_i) begin
      sl_retry_o <= 1'b0;
    end
  end

  // suppress raised at the start of a long transfer, two cycles after
  // select, held until the finishing edge; an abort drops it one cycle
  // after select falls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sl_tout_sup_o <= 1'b0;
    end else if (start && !ctrl[`PBS_CTRL_RTY_BIT] && lat > LAT_MAX) begin
      sl_tout_sup_o <= 1'b1;
    end else if (finish || aborted) begin
      sl_tout_sup_o <= 1'b0;
    end
  end

  // read data only in the acknowledge cycle, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sl_rdata_o <= '0;
    end else if (finish && opb_rnw_i) begin
      sl_rdata_o <= mem[idx];
    end else begin
      sl_rdata_o <= '0;
    end
  end

  // application words; written at the finishing edge so an abort
  // leaves them untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < mem_depth; i++) begin
        mem[i] <= '0;
      end
    end else if (finish && !opb_rnw_i) begin
      mem[idx] <= merge(mem[idx], opb_wdata_i, opb_be_i);
    end
  end

  // completed and aborted transfer counters, wrap on overflow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xfer_cnt <= '0;
      abort_cnt <= '0;
    end else begin
      if (finish) begin
        xfer_cnt <= xfer_cnt + 1'b1;
      end
      if (aborted) begin
        abort_cnt <= abort_cnt + 1'b1;
      end
    end
  end

  // wishbone slave: answer one cycle after the strobe, drop after one
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // control register write, byte lanes honoured; lands at the edge the
  // master samples ack, so a write counts exactly once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `PBS_CTRL_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == `PBS_CTRL_OFS) begin
      ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
    end
  end

  // read mux; unmapped offsets read zero and still acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `PBS_CTRL_OFS: wb_dat_o <= ctrl;
        `PBS_STAT_OFS: wb_dat_o <= {abort_cnt, xfer_cnt};
        default: wb_dat_o <= '0;
      endcase
    end else begin
      wb_dat_o <= '0;
    end
  end

  // helper: cycles since select rose, and whether any response came yet
  logic [5:0] sel_age;
  logic answered;
  always_ff @(posedge clk_i) begin
    if (rst_i || !opb_select_i) begin
      sel_age <= '0;
      answered <= 1'b0;
    end else begin
      sel_age <= (sel_age == 6'h3F) ? sel_age : sel_age + 1'b1;
      if (sl_tout_sup_o || sl_xfer_ack_o || sl_retry_o) begin
        answered <= 1'b1;
      end
    end
  end

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    sl_xfer_ack_o |=> !sl_xfer_ack_o)
    else $error("acknowledge longer than one cycle");

  a_ack_not_retry: assert property (@(posedge clk_i) disable iff (rst_i)
    !(sl_xfer_ack_o && sl_retry_o))
    else $error("acknowledge together with retry");

  a_err_with_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    sl_err_ack_o |-> sl_xfer_ack_o && $past(opb_select_i) && $past(hit_q, 2))
    else $error("error outside a selected acknowledge");

  a_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == PBS_IDLE && $past(state) == PBS_IDLE && !$past(hit_q))
      |-> sl_rdata_o == '0 && !sl_xfer_ack_o && !sl_err_ack_o && !sl_retry_o
        && !sl_tout_sup_o)
    else $error("idle slave drives nonzero output");

  a_resp_window: assert property (@(posedge clk_i) disable iff (rst_i)
    (opb_select_i && hit_q && state != PBS_IDLE && sel_age == 6'(`PBS_RESP_CYC))
      |-> answered || sl_tout_sup_o || sl_xfer_ack_o || sl_retry_o)
    else $error("no response within the timeout window");

  a_tout_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (sl_tout_sup_o && opb_select_i && !finish) |=> sl_tout_sup_o)
    else $error("suppress dropped before completion");

  a_tout_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    (sl_tout_sup_o && $fell(opb_select_i)) |=> !sl_tout_sup_o)
    else $error("suppress held too long after abort");

  a_hit_reg: assert property (@(posedge clk_i) disable iff (rst_i)
    (opb_select_i && opb_addr_i[31 -: decoded_msb_count] != range_base[31 -: decoded_msb_count])
      |=> !hit_q)
    else $error("foreign address registered as hit");

  a_hit_match: assert property (@(posedge clk_i) disable iff (rst_i)
    (opb_select_i && opb_addr_i[31 -: decoded_msb_count] == range_base[31 -: decoded_msb_count])
      |=> hit_q)
    else $error("own address not registered as hit");

  a_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    (start && !ctrl[`PBS_CTRL_RTY_BIT] && lat == '0)
      ##1 opb_select_i |=> sl_xfer_ack_o)
    else $error("zero latency acknowledge late");

  a_wb_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone acknowledge timing wrong");
endmodule : pbs_slave
`default_nettype wire

//--- testbench/pbs_arb_model.sv
`timescale 1ns/1ps
`default_nettype none
// arbiter watchdog: counts select cycles left without an answer
module pbs_arb_model (
  // bus side
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sel_i,
  input wire logic ack_i,
  input wire logic rty_i,
  input wire logic sup_i,
  // timeout flag
  output logic tout_o
);
  logic [4:0] cnt;
  // count halts while suppress is high, clears on answer
  always_ff @(posedge clk_i) begin
    if (rst_i || !sel_i || ack_i || rty_i) begin
      cnt <= 5'h00;
    end else if (!sup_i && cnt != 5'h10) begin
      cnt <= cnt + 5'h01;
    end
  end
  assign tout_o = (cnt == 5'h10);
endmodule : pbs_arb_model
`default_nettype wire

//--- testbench/tb_peripheral_bus_slave_decode.sv
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_bus_slave_decode;
  import pbs_pkg::*;
  // drive and observe
  logic clk_i = 0, rst_i = 1, sel = 0, rnw = 0, cyc = 0, stb = 0, we = 0, tmo = 0, e, rt;
  logic ack, err, rty, sup, wack, tout;
  logic [7:0] adr = 0;
  logic [3:0] be = 0;
  logic [3:0] wsel = 4'hF;
  logic [31:0] addr = 0, wd = 0, wdat = 0, r = 32'h5123B0CD, q, q0, m, wdo;
  logic [31:0] mem [4] = '{default: 0};
  logic [31:0] miss [3] = '{32'hFFFF_7FFC, 32'hFFFF_8100, 32'h0000_8000};
  pbs_word_t rdata;
  int fail_count = 0, compares = 0, n, ns;
  pbs_slave u_dut (.clk_i(clk_i), .rst_i(rst_i), .opb_addr_i(addr), .opb_be_i(be), .opb_wdata_i(wd),
    .opb_rnw_i(rnw), .opb_select_i(sel), .sl_rdata_o(rdata), .sl_xfer_ack_o(ack), .sl_err_ack_o(err),
    .sl_retry_o(rty), .sl_tout_sup_o(sup), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(wdo), .wb_ack_o(wack));
  pbs_arb_model u_arb (.clk_i(clk_i), .rst_i(rst_i), .sel_i(sel), .ack_i(ack), .rty_i(rty),
    .sup_i(sup), .tout_o(tout));
  always #25 clk_i = ~clk_i;
  // sticky: any arbiter timeout is a failure at the end
  always @(posedge clk_i) if (tout) tmo <= 1'b1;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  // classic single cycle, request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wack !== 1'b1);
    o = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // one transfer, select held until ack or retry is sampled
  task automatic xfer(input logic [31:0] a, input logic w, input logic [3:0] b, input logic [31:0] d);
    sel <= 1'b1;
    addr <= a;
    rnw <= !w;
    be <= b;
    wd <= d;
    n = 0;
    ns = 0;
    do begin
      @(posedge clk_i);
      n++;
      ns += sup;
    end while (ack !== 1'b1 && rty !== 1'b1);
    q = rdata;
    e = err;
    rt = rty;
    chk({31'h0, ack & rty}, 0);
    sel <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, ack}, 0);
    chk(rdata, 0);
    @(posedge clk_i);
    chk({28'h0, ack, err, rty, sup}, 0);
  endtask : xfer
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({27'h0, ack, err, rty, sup, wack} | rdata, 0);
    // control readback, read-only status, unmapped hole
    wb(1, 8'h00, 32'h31F, q);
    wb(0, 8'h00, 0, q);
    chk(q, 32'h31F);
    // lane 0 only: upper bytes of the control word must survive
    wsel <= 4'h1;
    wb(1, 8'h00, 32'hFFFF_FFE0, q);
    wsel <= 4'hF;
    wb(0, 8'h00, 0, q);
    chk(q, 32'h3E0);
    wb(1, 8'h04, 32'hFFFF_FFFF, q);
    wb(0, 8'h04, 0, q);
    chk(q, 0);
    wb(1, 8'h08, 32'hFFFF_FFFF, q);
    wb(0, 8'h08, 0, q);
    chk(q, 0);
    $display("done: registers");
    // random latency, direction, lanes and word
    for (int i = 0; i < 24; i++) begin
      r = lfsr(r);
      wb(1, 8'h00, {27'h0, r[4:0]}, q);
      m = {{8{r[11]}}, {8{r[10]}}, {8{r[9]}}, {8{r[8]}}};
      xfer({24'hFFFF80, r[19:12]}, r[5], r[11:8], ~r);
      chk(n, 4 + r[4:0]);
      chk(ns, r[4:0] > 12 ? r[4:0] + 1 : 0);
      chk({31'h0, e}, 0);
      if (r[5]) mem[r[15:14]] = (mem[r[15:14]] & ~m) | (~r & m);
      else chk(q, mem[r[15:14]]);
    end
    $display("done: random transfers");
    // forced error, then forced retry
    wb(1, 8'h00, 32'h100, q);
    xfer(32'hFFFF_8000, 0, 4'hF, 0);
    chk({31'h0, e}, 1);
    wb(1, 8'h00, 32'h200, q);
    xfer(32'hFFFF_80FC, 0, 4'hF, 0);
    chk({31'h0, rt}, 1);
    chk(n, 3);
    $display("done: error and retry");
    // neighbours just outside the decoded prefix and an upper-half mismatch stay silent
    foreach (miss[k]) begin
      sel <= 1'b1;
      addr <= miss[k];
      // held below the arbiter window: nobody answers a miss
      repeat (14) begin
        @(posedge clk_i);
        chk(rdata | {28'h0, ack, err, rty, sup}, 0);
      end
      sel <= 1'b0;
      @(posedge clk_i);
    end
    $display("done: misses");
    // abort a suppressed write in mid-wait
    wb(1, 8'h00, 32'h14, q);
    wb(0, 8'h04, 0, q0);
    sel <= 1'b1;
    addr <= 32'hFFFF_8010;
    rnw <= 1'b0;
    be <= 4'hF;
    wd <= 32'hA5A5_A5A5;
    repeat (5) @(posedge clk_i);
    chk({31'h0, sup}, 1);
    sel <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({31'h0, sup}, 0);
    repeat (30) begin
      @(posedge clk_i);
      chk({31'h0, ack}, 0);
    end
    wb(0, 8'h04, 0, q);
    chk(q[31:16], q0[31:16] + 16'h1);
    wb(1, 8'h00, 0, q);
    xfer(32'hFFFF_8000, 0, 4'hF, 0);
    chk(q, mem[0]);
    chk({31'h0, tmo}, 0);
    $display("done: abort");
    summarize();
  end
endmodule : tb_peripheral_bus_slave_decode
`default_nettype wire
